// file: rtl/brk_defs.vh
`ifndef BRK_DEFS_VH
`define BRK_DEFS_VH

// ------------------------------------------------------------
// register offsets (local port)
// ------------------------------------------------------------
`define OFS_BRK_HIGH     3'h0
`define OFS_BRK_LOW      3'h1
`define OFS_BRK_SCR      3'h2
`define OFS_IRQ_STATUS   3'h3
`define OFS_IRQ_MASK     3'h4
`define OFS_SYS_CTRL     3'h5

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BIT_BRK_ENABLE   7
`define BIT_BRK_ACTIVE   6
`define BIT_CLR_FLAG_EN  0
`define BIT_BRK_WAIT     1
`define BIT_MONITOR      2
`define BIT_EV_MATCH     0
`define BIT_EV_SOFT      1
`define BIT_EV_WAIT      2

// ------------------------------------------------------------
// reset values and vectors
// ------------------------------------------------------------
`define RST_BYTE         8'h00
`define VEC_USER         16'hFFFC
`define VEC_MONITOR      16'hFEFC

`endif

// file: rtl/brk_addr_store.v
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// break address byte store, registered read
// ------------------------------------------------------------
module brk_addr_store
(
  input  wire       sys_clk,
  input  wire       reset,
  input  wire       wr_en,
  input  wire       wr_sel,
  input  wire [7:0] wr_data,
  input  wire       rd_sel,
  output reg  [7:0] rd_data,
  output wire [15:0] match_addr
);

  reg [7:0] byte_r [0:1];

  assign match_addr = {byte_r[1], byte_r[0]};

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      byte_r[0] <= 8'h00;
      byte_r[1] <= 8'h00;
      rd_data   <= 8'h00;
    end
    else
    begin
      if (wr_en)
        byte_r[wr_sel] <= wr_data;
      rd_data <= byte_r[rd_sel];
    end
  end

endmodule

`default_nettype wire

// file: rtl/address_breakpoint_unit.v
`timescale 1ns/1ps
`default_nettype none
`include "brk_defs.vh"

// Operation
// - address equal break address raises breakpoint request
// - compare current program counter, both bytes
// - request makes cpu load software interrupt instruction
// - vector user FFFC, monitor FEFC
// - break starts after instruction; immediate on last
// - writing one to active bit breaks
// - return from interrupt ends break state
// - enable bit 7 gates address matches
// - match sets break active bit
// - software zero write or reset clears active
// - address bytes reset to zero
// - timer counter halted during break
// - watchdog off in break with test voltage
// - break wait flag clearing in break needs clear enable
// - active in wait; break wait flag recorded
// - no breaks in stop mode
// - stop leaves registers unchanged
module address_breakpoint_unit
(
  input  wire        sys_clk,
  input  wire        reset,
  input  wire [2:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire [15:0] prog_addr,
  input  wire        fetch_valid,
  input  wire        instr_last_cycle,
  input  wire        rti_done,
  input  wire        wait_mode,
  input  wire        stop_mode,
  input  wire        high_test_voltage,
  output wire        breakpoint_request,
  output wire        force_swi,
  output wire [15:0] break_vector,
  output wire        break_state,
  output wire        timer_halt,
  output wire        watchdog_disable,
  output wire        status_clear_allow,
  output wire        irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  localparam ST_IDLE    = 3'b001;
  localparam ST_PENDING = 3'b010;
  localparam ST_BREAK   = 3'b100;

  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg         enable_r;
  reg         active_r;
  reg         clr_en_r;
  reg         monitor_r;
  reg         bwait_r;
  reg  [2:0]  stat_r;
  reg  [2:0]  mask_r;
  reg  [2:0]  rd_addr_r;
  reg  [7:0]  local_rd_r;
  wire [15:0] match_addr;
  wire [7:0]  addr_rdata;
  wire        addr_wr;
  wire        hit;
  wire        soft_brk;
  wire        req;

  function sel;
    input [2:0] a;
    input [2:0] ofs;
    begin
      sel = (a == ofs);
    end
  endfunction

  assign addr_wr = reg_wr & (sel(reg_addr, `OFS_BRK_HIGH) |
                             sel(reg_addr, `OFS_BRK_LOW));

  // ------------------------------------------------------------
  // address store
  // ------------------------------------------------------------
  brk_addr_store u_store
  (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .wr_en      (addr_wr),
    .wr_sel     (sel(reg_addr, `OFS_BRK_HIGH)),
    .wr_data    (reg_wdata),
    .rd_sel     (sel(reg_addr, `OFS_BRK_HIGH)),
    .rd_data    (addr_rdata),
    .match_addr (match_addr)
  );

  // ------------------------------------------------------------
  // match and request
  // ------------------------------------------------------------
  // stop mode kills both sources; wait mode does not
  assign hit = enable_r & fetch_valid & ~stop_mode &
               (prog_addr == match_addr);
  assign soft_brk = reg_wr & sel(reg_addr, `OFS_BRK_SCR) &
                    reg_wdata[`BIT_BRK_ACTIVE] & ~stop_mode;
  assign req = (hit | soft_brk) & state_r[0];

  assign breakpoint_request = ~state_r[0] | req;
  // swi injected only at an instruction boundary
  assign force_swi = (state_r[1] | req) & instr_last_cycle;
  assign break_vector = monitor_r ? `VEC_MONITOR : `VEC_USER;
  assign break_state = state_r[2];
  assign timer_halt = state_r[2];
  assign watchdog_disable = state_r[2] & high_test_voltage;
  assign status_clear_allow = ~state_r[2] | clr_en_r;
  assign irq = |(stat_r & mask_r);

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (req)
          state_nxt = instr_last_cycle ? ST_BREAK : ST_PENDING;
      ST_PENDING:
        if (instr_last_cycle)
          state_nxt = ST_BREAK;
      ST_BREAK:
        if (rti_done)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // stop mode gates nothing here, so contents survive it
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_r   <= ST_IDLE;
      enable_r  <= 1'b0;
      active_r  <= 1'b0;
      clr_en_r  <= 1'b0;
      monitor_r <= 1'b0;
      bwait_r   <= 1'b0;
      stat_r    <= 3'h0;
      mask_r    <= 3'h0;
      rd_addr_r <= 3'h0;
      local_rd_r <= `RST_BYTE;
    end
    else
    begin
      state_r   <= state_nxt;
      rd_addr_r <= reg_addr;
      if (reg_wr & sel(reg_addr, `OFS_BRK_SCR))
        enable_r <= reg_wdata[`BIT_BRK_ENABLE];
      // set wins over a clearing write in the same cycle
      if (hit | soft_brk)
        active_r <= 1'b1;
      else if (reg_wr & sel(reg_addr, `OFS_BRK_SCR) &
               ~reg_wdata[`BIT_BRK_ACTIVE])
        active_r <= 1'b0;
      if (reg_wr & sel(reg_addr, `OFS_SYS_CTRL))
      begin
        clr_en_r  <= reg_wdata[`BIT_CLR_FLAG_EN];
        monitor_r <= reg_wdata[`BIT_MONITOR];
      end
      if (req & wait_mode)
        bwait_r <= 1'b1;
      else if (reg_wr & sel(reg_addr, `OFS_SYS_CTRL) &
               ~reg_wdata[`BIT_BRK_WAIT] & status_clear_allow)
        bwait_r <= 1'b0;
      if (reg_wr & sel(reg_addr, `OFS_IRQ_MASK))
        mask_r <= reg_wdata[2:0];
      // read of status clears it, a new event same cycle wins
      stat_r <= ((reg_rd & sel(reg_addr, `OFS_IRQ_STATUS)) ? 3'h0 : stat_r)
                | {req & wait_mode, soft_brk, hit};
      if (reg_rd)
      begin
        case (reg_addr)
          `OFS_BRK_SCR:
            local_rd_r <= {enable_r, active_r, 6'h00};
          `OFS_IRQ_STATUS:
            local_rd_r <= {5'h00, stat_r};
          `OFS_IRQ_MASK:
            local_rd_r <= {5'h00, mask_r};
          `OFS_SYS_CTRL:
            local_rd_r <= {5'h00, monitor_r, bwait_r, clr_en_r};
          default:
            local_rd_r <= 8'h00;
        endcase
      end
      else
        local_rd_r <= 8'h00;
    end
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  reg rd_was_r;
  always @(posedge sys_clk)
  begin
    if (reset)
      rd_was_r <= 1'b0;
    else
      rd_was_r <= reg_rd;
  end

  always @*
  begin
    if (rd_was_r & (sel(rd_addr_r, `OFS_BRK_HIGH) |
                    sel(rd_addr_r, `OFS_BRK_LOW)))
      reg_rdata = addr_rdata;
    else
      reg_rdata = local_rd_r;
  end

endmodule

`default_nettype wire

// file: verification/address_breakpoint_unit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// break timing checks
// ----
module address_breakpoint_unit_monitor
(
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       instr_last_cycle,
  input wire logic       rti_done,
  input wire logic       stop_mode,
  input wire logic       high_test_voltage,
  input wire logic       breakpoint_request,
  input wire logic       force_swi,
  input wire logic       break_state,
  input wire logic       timer_halt,
  input wire logic       watchdog_disable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_swi; force_swi |-> instr_last_cycle && breakpoint_request;
  endproperty
  a_swi: assert property (p_swi) else $error("swi early");
  property p_req; breakpoint_request && instr_last_cycle && !break_state
    |-> force_swi; endproperty
  a_req: assert property (p_req) else $error("swi late");
  property p_fs; force_swi |=> break_state; endproperty
  a_fs: assert property (p_fs) else $error("no break");
  property p_st; $rose(break_state) |-> $past(force_swi); endproperty
  a_st: assert property (p_st) else $error("stray break");
  property p_rti; break_state && rti_done |=> !break_state; endproperty
  a_rti: assert property (p_rti) else $error("rti kept");
  property p_tmr; timer_halt == break_state; endproperty
  a_tmr: assert property (p_tmr) else $error("timer");
  property p_wdg; watchdog_disable == (break_state && high_test_voltage);
  endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog");
  property p_stp; $rose(breakpoint_request) |-> !stop_mode; endproperty
  a_stp: assert property (p_stp) else $error("stop break");
  property p_rd; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("rdata idle");
endmodule
bind address_breakpoint_unit address_breakpoint_unit_monitor u_mon
  (.sys_clk, .reset, .reg_rd, .reg_rdata, .instr_last_cycle, .rti_done,
   .stop_mode, .high_test_voltage, .breakpoint_request, .force_swi,
   .break_state, .timer_halt, .watchdog_disable);
`default_nettype wire

// file: verification/cpu_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// cpu stand-in: two-cycle instructions
// ----
module cpu_side_model
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        run,
  input  wire logic        break_state,
  output var  logic [15:0] prog_addr,
  output var  logic        fetch_valid,
  output var  logic        instr_last_cycle,
  output var  logic        rti_done
);
  logic [15:0] pc_r;
  logic [2:0]  hcnt_r;
  // not a fetch: scrambled address, must not match
  assign prog_addr = fetch_valid ? pc_r : ~pc_r;
  assign instr_last_cycle = run && !break_state && !fetch_valid;
  always @(posedge sys_clk)
  begin
    if (reset)
      pc_r <= 16'h1000;
    else if (instr_last_cycle)
      pc_r <= pc_r + 16'h0001;
    fetch_valid <= !reset && run && !break_state && !fetch_valid;
    hcnt_r <= break_state ? hcnt_r + 3'h1 : 3'h0;
    rti_done <= break_state && hcnt_r == 3'h6;
  end
endmodule
`default_nettype wire

// file: verification/address_breakpoint_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// bench
// ----
module address_breakpoint_unit_bench;
  logic sys_clk, reset, reg_wr, reg_rd, run, wait_mode, stop_mode;
  logic high_test_voltage, fetch_valid, instr_last_cycle, rti_done;
  logic breakpoint_request, force_swi, break_state, timer_halt, irq;
  logic watchdog_disable, status_clear_allow;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [15:0] prog_addr, break_vector;
  int          bad_count, checks_done, i;
  // index, write data, read-back; 7 is unmapped
  logic [18:0] rows [0:5] = '{{3'h0, 8'h10, 8'h10}, {3'h1, 8'h08, 8'h08},
    {3'h2, 8'h9F, 8'h80}, {3'h4, 8'h07, 8'h07}, {3'h5, 8'h04, 8'h04},
    {3'h7, 8'hFF, 8'h00}};
  address_breakpoint_unit u_dut (.sys_clk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .prog_addr, .fetch_valid,
    .instr_last_cycle, .rti_done, .wait_mode, .stop_mode,
    .high_test_voltage, .breakpoint_request, .force_swi, .break_vector,
    .break_state, .timer_halt, .watchdog_disable, .status_clear_allow, .irq);
  cpu_side_model u_cpu (.sys_clk, .reset, .run, .break_state, .prog_addr,
    .fetch_valid, .instr_last_cycle, .rti_done);
  task automatic chk(input logic ok);
    checks_done++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("Error %0t check %0d failed", $time, checks_done);
    end
  endtask
  // one access, then an idle cycle so strobes never collide
  task automatic op(input logic w, input logic [2:0] a, input logic [7:0] d);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'b00;
    #1 if (!w) chk(reg_rdata === d);
    @(posedge sys_clk);
  endtask
  task automatic brk;
    run <= 1'b1;
    // look once before the edge: a pending break may fire at once
    #1;
    for (i = 0; i < 60 && force_swi !== 1'b1; i++) @(posedge sys_clk) #1;
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial forever #2 sys_clk = ~sys_clk;
  initial
  begin
    #5000;
    bad_count++;
    stop_test;
  end
  initial
  begin
    {sys_clk, reset, reg_wr, reg_rd, run, reg_addr, reg_wdata} = 16'h4000;
    {wait_mode, stop_mode, high_test_voltage} = 3'b000;
    bad_count = 0;
    checks_done = 0;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk) #1;
    chk({break_vector, status_clear_allow} === 17'h1FFF9);
    for (i = 0; i < 6; i++) op(0, rows[i][18:16], 8'h00);
    for (i = 0; i < 6; i++)
    begin
      op(1, rows[i][18:16], rows[i][15:8]);
      op(0, rows[i][18:16], rows[i][7:0]);
    end
    {wait_mode, high_test_voltage} <= 2'b11;
    brk;
    chk({prog_addr, breakpoint_request} === 17'h1DFEF);
    chk(break_vector === 16'hFEFC);
    // keep the last cycle standing until the edge that takes the swi
    @(posedge sys_clk);
    run <= 1'b0;
    #1;
    chk({break_state, timer_halt, watchdog_disable, status_clear_allow, irq}
      === 5'b11101);
    op(0, 3'h3, 8'h05);
    chk(irq === 1'b0);
    op(0, 3'h2, 8'hC0);
    repeat (4) @(posedge sys_clk) #1;
    chk(break_state === 1'b0);
    wait_mode <= 1'b0;
    op(0, 3'h5, 8'h06);
    op(1, 3'h2, 8'h80);
    op(0, 3'h2, 8'h80);
    op(1, 3'h4, 8'h00);
    op(1, 3'h2, 8'hC0);
    chk({breakpoint_request, irq} === 2'b10);
    op(0, 3'h3, 8'h02);
    brk;
    chk(force_swi === 1'b1);
    @(posedge sys_clk);
    run <= 1'b0;
    repeat (12) @(posedge sys_clk);
    op(1, 3'h2, 8'h80);
    stop_mode <= 1'b1;
    op(1, 3'h2, 8'hC0);
    chk(breakpoint_request === 1'b0);
    op(0, 3'h0, 8'h10);
    stop_test;
  end
endmodule
`default_nettype wire
